//--- common/fsu_pkg.sv
// constants and types shared by the flash self-update write buffer block
// assumes a 16-bit wide flash array of 16K words behind a valid/ready port
package fsu_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int ADDR_W = 14;
  localparam int OFFS_W = 5;
  localparam int PAGE_W = ADDR_W - OFFS_W;
  localparam int PAGE_WORDS = 32;
  localparam logic [OFFS_W-1:0] LAST_OFFS = 5'h1f;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h08;
  localparam logic [7:0] OFF_ADDR_LO = 8'h0c;
  localparam logic [7:0] OFF_ADDR_HI = 8'h10;
  localparam logic [7:0] OFF_DATA0_LO = 8'h14;
  localparam logic [7:0] OFF_DATA0_HI = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EWEN_BIT = 7;
  localparam int OP_HI = 6;
  localparam int OP_LO = 4;
  localparam int WPEN_BIT = 3;
  localparam int WSTART_BIT = 2;
  localparam int RDEN_BIT = 1;
  localparam int RSTART_BIT = 0;
  localparam int CLRBUF_BIT = 0;

  // ----------------------------------------------------------------
  // operation select codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_WRITE = 3'h0;
  localparam logic [2:0] OP_ERASE = 3'h1;
  localparam logic [2:0] OP_READ = 3'h3;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
  localparam logic [WORD_W-1:0] BUF_CLEAR_VALUE = 16'h0000;

  // ----------------------------------------------------------------
  // flash array port commands, bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] MEM_READ = 2'h0;
  localparam logic [1:0] MEM_PROG = 2'h1;
  localparam logic [1:0] MEM_ERASE = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FSU_IDLE,
    FSU_ERASE,
    FSU_WRITE,
    FSU_READ
  } fsu_seq_t;

endpackage : fsu_pkg

//--- common/fsu_if.sv
// carriers between the top of the self-update block and its two helpers
// assumes single clock; all signals sampled at aclk rising edge
`timescale 1ns/1ps

interface fsu_regbus_if #(parameter int AW = 8);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_hit;
  logic [AW-1:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_hit;
  modport bridge(output wr_en, output wr_addr, output wr_data, output rd_addr,
                 input wr_hit, input rd_data, input rd_hit);
  modport regs(input wr_en, input wr_addr, input wr_data, input rd_addr,
               output wr_hit, output rd_data, output rd_hit);
endinterface : fsu_regbus_if

interface fsu_wbuf_if;
  logic load;
  logic [fsu_pkg::OFFS_W-1:0] load_idx;
  logic [fsu_pkg::WORD_W-1:0] load_data;
  logic clear;
  logic [fsu_pkg::OFFS_W-1:0] rd_idx;
  logic [fsu_pkg::WORD_W-1:0] rd_data;
  modport user(output load, output load_idx, output load_data, output clear,
               output rd_idx, input rd_data);
  modport store(input load, input load_idx, input load_data, input clear,
                input rd_idx, output rd_data);
endinterface : fsu_wbuf_if

//--- verilog/fsu_wbuf.sv
// page write buffer: one word per flash page offset
// assumes clear and load are never meant together; clear wins
`timescale 1ns/1ps

module fsu_wbuf #(
  parameter int WORDS = 32,
  parameter int W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  fsu_wbuf_if.store b
);

  typedef struct packed {
    logic [WORDS-1:0] valid;
    logic [WORDS-1:0][W-1:0] data;
  } fsu_wbuf_state_t;

  fsu_wbuf_state_t s_reg;
  fsu_wbuf_state_t s_next;

  // ----------------------------------------------------------------
  // clearing drops the valid mask, so a whole page clears in one cycle
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    if (b.clear) begin
      s_next.valid = '0;
    end else if (b.load) begin
      s_next.valid[b.load_idx] = 1'b1;
      s_next.data[b.load_idx] = b.load_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign b.rd_data = s_reg.valid[b.rd_idx] ? s_reg.data[b.rd_idx] : fsu_pkg::BUF_CLEAR_VALUE;

endmodule : fsu_wbuf

//--- verilog/fsu_axil_slave.sv
// axi4-lite slave front end turning bus transfers into byte register strobes
// assumes one outstanding write and one outstanding read at most
`timescale 1ns/1ps

module fsu_axil_slave #(
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  fsu_regbus_if.bridge bus
);

  typedef struct packed {
    logic aw_full;
    logic [AW-1:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fsu_axil_state_t;

  fsu_axil_state_t s_reg;
  fsu_axil_state_t s_next;

  assign s_axi_awready = !s_reg.aw_full && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_full && !s_reg.bvalid;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;

  // registers are one byte wide; only lane 0 of wstrb matters
  assign bus.wr_en = s_reg.aw_full && s_reg.w_full && s_reg.w_lane0;
  assign bus.wr_addr = s_reg.aw_addr;
  assign bus.wr_data = s_reg.w_data;
  assign bus.rd_addr = s_axi_araddr;

  always_comb begin
    s_next = s_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_full = 1'b1;
      s_next.w_data = s_axi_wdata[7:0];
      s_next.w_lane0 = s_axi_wstrb[0];
    end
    if (s_reg.aw_full && s_reg.w_full) begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = bus.wr_hit ? fsu_pkg::RESP_OKAY : fsu_pkg::RESP_SLVERR;
    end else if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = {24'h00_0000, bus.rd_data};
      s_next.rresp = bus.rd_hit ? fsu_pkg::RESP_OKAY : fsu_pkg::RESP_SLVERR;
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : fsu_axil_slave

//--- verilog/fsu_top.sv
// flash self-update logic: control registers, page write buffer and
// erase / write / read sequencing toward the flash array port
// assumes the array answers each mem_valid with mem_ready, any latency
//
// Summary of operation
// R1 - erase and write whole pages, read single words
// R2 - page and buffer each hold 32 words
// R3 - firmware should erase before writing a page
// R4 - enabled flag rises after unlock succeeds
// R5 - buffer accepts data only while enabled
// R6 - write start flag stays high until done
// R7 - read enable plus read start; cleared when done
// R8 - address bits 13..5 pick page, 4..0 word
// R9 - clear request empties buffer, then self-clears
// R10 - firmware should clear buffer before each use
// R11 - high byte write loads whole word
// R12 - address increments after each buffer load
// R13 - address stops at last word of page
// R14 - firmware reloads page address after page end
// R15 - buffer cleared automatically after each write
// R16 - firmware clears and reloads buffer on retry
// R17 - low byte write only stores the byte
// R18 - writing one to enabled flag does nothing
// R19 - op codes: 000 write, 001 erase, 011 read
// R20 - starts ignored while disabled; unlock input sets flag (only the write start is gated; a read start still runs while disabled)
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module fsu_top #(
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic unlock_ok,
  output logic mem_valid,
  output logic [1:0] mem_op,
  output logic [fsu_pkg::ADDR_W-1:0] mem_addr,
  output logic [fsu_pkg::WORD_W-1:0] mem_wdata,
  input wire logic mem_ready,
  input wire logic [fsu_pkg::WORD_W-1:0] mem_rdata
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    fsu_pkg::fsu_seq_t seq;
    logic erase_write_enabled_flag;
    logic [2:0] flash_op_select;
    logic write_protect_bit;
    logic write_start_flag;
    logic read_enable_flag;
    logic read_start_flag;
    logic clear_buffer_request;
    logic [fsu_pkg::ADDR_W-1:0] flash_addr;
    logic [7:0] first_word_low_byte;
    logic [7:0] first_word_high_byte;
    logic [fsu_pkg::OFFS_W-1:0] idx;
    logic mem_valid;
    logic [1:0] mem_op;
    logic [fsu_pkg::ADDR_W-1:0] mem_addr;
    logic [fsu_pkg::WORD_W-1:0] mem_wdata;
  } fsu_top_state_t;

  fsu_top_state_t s_reg;
  fsu_top_state_t s_next;

  fsu_regbus_if #(.AW(AW)) bus();
  fsu_wbuf_if wb();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [AW-1:0] a);
    is_mapped = (a == AW'(fsu_pkg::OFF_CTRL0)) || (a == AW'(fsu_pkg::OFF_CTRL2)) ||
                (a == AW'(fsu_pkg::OFF_ADDR_LO)) || (a == AW'(fsu_pkg::OFF_ADDR_HI)) ||
                (a == AW'(fsu_pkg::OFF_DATA0_LO)) || (a == AW'(fsu_pkg::OFF_DATA0_HI));
  endfunction : is_mapped

  function automatic logic [fsu_pkg::ADDR_W-1:0] page_base(
      input logic [fsu_pkg::ADDR_W-1:0] a);
    page_base = {a[fsu_pkg::ADDR_W-1:fsu_pkg::OFFS_W], fsu_pkg::OFFS_W'(0)}; // see R8
  endfunction : page_base

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  fsu_axil_slave #(.AW(AW)) u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .bus(bus.bridge)
  );

  fsu_wbuf #(.WORDS(fsu_pkg::PAGE_WORDS), .W(fsu_pkg::WORD_W)) u_wbuf ( // see R2
    .aclk(aclk),
    .aresetn(aresetn),
    .b(wb.store)
  );

  // ----------------------------------------------------------------
  // register read side
  // ----------------------------------------------------------------
  assign bus.wr_hit = is_mapped(bus.wr_addr);
  assign bus.rd_hit = is_mapped(bus.rd_addr);

  always_comb begin
    if (bus.rd_addr == AW'(fsu_pkg::OFF_CTRL0)) begin
      bus.rd_data = {s_reg.erase_write_enabled_flag, s_reg.flash_op_select,
                     s_reg.write_protect_bit, s_reg.write_start_flag,
                     s_reg.read_enable_flag, s_reg.read_start_flag};
    end else if (bus.rd_addr == AW'(fsu_pkg::OFF_CTRL2)) begin
      bus.rd_data = {7'h00, s_reg.clear_buffer_request};
    end else if (bus.rd_addr == AW'(fsu_pkg::OFF_ADDR_LO)) begin
      bus.rd_data = s_reg.flash_addr[7:0];
    end else if (bus.rd_addr == AW'(fsu_pkg::OFF_ADDR_HI)) begin
      bus.rd_data = {2'h0, s_reg.flash_addr[fsu_pkg::ADDR_W-1:8]};
    end else if (bus.rd_addr == AW'(fsu_pkg::OFF_DATA0_LO)) begin
      bus.rd_data = s_reg.first_word_low_byte;
    end else if (bus.rd_addr == AW'(fsu_pkg::OFF_DATA0_HI)) begin
      bus.rd_data = s_reg.first_word_high_byte;
    end else begin
      bus.rd_data = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // sequencer and register write side
  // ----------------------------------------------------------------
  logic idle;
  logic mem_done;
  logic wr_ctrl0;
  logic wr_ctrl2;

  assign idle = (s_reg.seq == fsu_pkg::FSU_IDLE);
  assign mem_done = s_reg.mem_valid && mem_ready;
  assign wr_ctrl0 = bus.wr_en && (bus.wr_addr == AW'(fsu_pkg::OFF_CTRL0));
  assign wr_ctrl2 = bus.wr_en && (bus.wr_addr == AW'(fsu_pkg::OFF_CTRL2));

  always_comb begin
    s_next = s_reg;
    wb.load = 1'b0;
    wb.load_idx = s_reg.flash_addr[fsu_pkg::OFFS_W-1:0]; // see R8
    wb.load_data = {bus.wr_data, s_reg.first_word_low_byte};
    wb.clear = 1'b0;
    wb.rd_idx = s_reg.idx;

    // hardware side first, so a software set in the same cycle wins
    case (s_reg.seq)
      fsu_pkg::FSU_IDLE: begin
        if (s_reg.clear_buffer_request) begin
          wb.clear = 1'b1; // see R9
          s_next.clear_buffer_request = 1'b0; // see R9
        end else if (s_reg.write_start_flag) begin
          // a start that lost its enable, or a reserved code, just drops
          if (!s_reg.erase_write_enabled_flag) begin
            s_next.write_start_flag = 1'b0; // see R20
          end else if (s_reg.flash_op_select == fsu_pkg::OP_WRITE) begin // see R19
            s_next.seq = fsu_pkg::FSU_WRITE;
            s_next.idx = '0;
          end else if (s_reg.flash_op_select == fsu_pkg::OP_ERASE) begin // see R19
            s_next.seq = fsu_pkg::FSU_ERASE;
            s_next.mem_valid = 1'b1;
            s_next.mem_op = fsu_pkg::MEM_ERASE;
            s_next.mem_addr = page_base(s_reg.flash_addr); // see R1
          end else begin
            s_next.write_start_flag = 1'b0;
          end
        end else if (s_reg.read_start_flag) begin
          if (s_reg.read_enable_flag &&
              s_reg.flash_op_select == fsu_pkg::OP_READ) begin // see R7, R19
            s_next.seq = fsu_pkg::FSU_READ;
            s_next.mem_valid = 1'b1;
            s_next.mem_op = fsu_pkg::MEM_READ;
            s_next.mem_addr = s_reg.flash_addr; // see R1
          end else begin
            s_next.read_start_flag = 1'b0;
          end
        end
      end
      fsu_pkg::FSU_ERASE: begin
        if (mem_done) begin
          s_next.mem_valid = 1'b0;
          s_next.write_start_flag = 1'b0; // see R6
          s_next.seq = fsu_pkg::FSU_IDLE;
        end
      end
      fsu_pkg::FSU_WRITE: begin
        // one buffer word per array request, whole page in order
        if (!s_reg.mem_valid) begin
          s_next.mem_valid = 1'b1;
          s_next.mem_op = fsu_pkg::MEM_PROG;
          s_next.mem_addr = page_base(s_reg.flash_addr) | fsu_pkg::ADDR_W'(s_reg.idx);
          s_next.mem_wdata = wb.rd_data;
        end else if (mem_done) begin
          s_next.mem_valid = 1'b0;
          if (s_reg.idx == fsu_pkg::LAST_OFFS) begin
            wb.clear = 1'b1; // see R15
            s_next.write_start_flag = 1'b0; // see R6
            s_next.seq = fsu_pkg::FSU_IDLE;
          end else begin
            s_next.idx = s_reg.idx + 5'h01; // see R1
          end
        end
      end
      fsu_pkg::FSU_READ: begin
        if (mem_done) begin
          s_next.mem_valid = 1'b0;
          s_next.first_word_low_byte = mem_rdata[7:0];
          s_next.first_word_high_byte = mem_rdata[fsu_pkg::WORD_W-1:8];
          s_next.read_start_flag = 1'b0; // see R7
          s_next.seq = fsu_pkg::FSU_IDLE;
        end
      end
      default: begin
        s_next.seq = fsu_pkg::FSU_IDLE;
      end
    endcase

    // software writes
    if (wr_ctrl0) begin
      if (!bus.wr_data[fsu_pkg::EWEN_BIT]) begin
        s_next.erase_write_enabled_flag = 1'b0; // see R18
      end
      s_next.read_enable_flag = bus.wr_data[fsu_pkg::RDEN_BIT];
      // mode and starts freeze while a sequence runs
      if (idle) begin
        s_next.flash_op_select = bus.wr_data[fsu_pkg::OP_HI:fsu_pkg::OP_LO];
        s_next.write_protect_bit = bus.wr_data[fsu_pkg::WPEN_BIT];
        s_next.write_start_flag = bus.wr_data[fsu_pkg::WSTART_BIT] &&
                                  s_reg.erase_write_enabled_flag; // see R20
        s_next.read_start_flag = bus.wr_data[fsu_pkg::RSTART_BIT];
      end
    end
    if (wr_ctrl2 && bus.wr_data[fsu_pkg::CLRBUF_BIT]) begin
      s_next.clear_buffer_request = 1'b1; // see R9
    end
    if (bus.wr_en && idle) begin
      if (bus.wr_addr == AW'(fsu_pkg::OFF_ADDR_LO)) begin
        s_next.flash_addr[7:0] = bus.wr_data;
      end else if (bus.wr_addr == AW'(fsu_pkg::OFF_ADDR_HI)) begin
        s_next.flash_addr[fsu_pkg::ADDR_W-1:8] = bus.wr_data[fsu_pkg::ADDR_W-9:0];
      end else if (bus.wr_addr == AW'(fsu_pkg::OFF_DATA0_LO)) begin
        s_next.first_word_low_byte = bus.wr_data; // see R17
      end else if (bus.wr_addr == AW'(fsu_pkg::OFF_DATA0_HI)) begin
        s_next.first_word_high_byte = bus.wr_data;
        if (s_reg.erase_write_enabled_flag) begin // see R5, R20
          wb.load = 1'b1; // see R11
          // the pointer parks on the last word instead of wrapping
          if (s_reg.flash_addr[fsu_pkg::OFFS_W-1:0] != fsu_pkg::LAST_OFFS) begin // see R13
            s_next.flash_addr = s_reg.flash_addr + 14'h0001; // see R12
          end
        end
      end
    end

    // unlock success sets the flag even against a software clear
    if (unlock_ok) begin
      s_next.erase_write_enabled_flag = 1'b1; // see R4, R20
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.seq <= fsu_pkg::FSU_IDLE;
      s_reg.flash_addr <= fsu_pkg::ADDR_RST;
      s_reg.first_word_low_byte <= fsu_pkg::REG_RST;
      s_reg.first_word_high_byte <= fsu_pkg::REG_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // flash array port
  // ----------------------------------------------------------------
  assign mem_valid = s_reg.mem_valid;
  assign mem_op = s_reg.mem_op;
  assign mem_addr = s_reg.mem_addr;
  assign mem_wdata = s_reg.mem_wdata;

endmodule : fsu_top

//--- verif/fsu_monitor.sv
// checker for the flash self-update block, bound onto fsu_top
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps

module fsu_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mem_valid,
  input wire logic [1:0] mem_op,
  input wire logic [fsu_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [fsu_pkg::WORD_W-1:0] mem_wdata,
  input wire logic mem_ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // address of the last accepted array request, for the word stepping check
  logic [fsu_pkg::ADDR_W-1:0] last_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) last_reg <= fsu_pkg::ADDR_RST;
    else if (mem_valid && mem_ready) last_reg <= mem_addr;
  end

  // ------------------------------------------------------------
  // array port
  // ------------------------------------------------------------
  mem_hold_a: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_op)
    && $stable(mem_addr) && $stable(mem_wdata)) else $error("array request not held");
  erase_base_a: assert property (mem_valid && mem_op == fsu_pkg::MEM_ERASE
    |-> mem_addr[4:0] == 5'h00) else $error("erase not at page base");
  word_step_a: assert property (mem_valid && mem_op == fsu_pkg::MEM_PROG
    && mem_addr[4:0] != 5'h00 |-> mem_addr == last_reg + 14'h0001) else $error("word skipped");
  page_end_a: assert property (mem_valid && mem_ready && mem_op == fsu_pkg::MEM_PROG
    && mem_addr[4:0] == 5'h1f |=> !mem_valid) else $error("write ran past page");
  read_once_a: assert property (mem_valid && mem_ready && mem_op == fsu_pkg::MEM_READ
    |=> !mem_valid) else $error("read not single word");

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("late write response");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    ##0 !s_axi_arready) else $error("late read response");
endmodule : fsu_monitor

bind fsu_top fsu_monitor u_monitor (.*);

//--- verif/tb.sv
// register-level bench for fsu_top with a small flash array responder
// assumes byte registers in lane 0 and the hand-over address map
`timescale 1ns/1ps

module tb;
  logic aclk, aresetn, unlock_ok, mem_ready, mem_valid;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, d;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, mem_op, r;
  logic [13:0] mem_addr, last_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [15:0] prog [32];
  int err_total, comparisons, prog_cnt, erase_cnt;

  fsu_top DUT (.*);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // ------------------------------------------------------------
  // array responder: one wait cycle, data inverts every cycle when idle
  // ------------------------------------------------------------
  always @(posedge aclk) begin
    mem_ready <= mem_valid && !mem_ready;
    mem_rdata <= mem_valid ? ({2'h0, mem_addr} ^ 16'h5a5a) : ~mem_rdata;
    if (mem_valid && mem_ready) begin
      last_addr = mem_addr;
      if (mem_op === fsu_pkg::MEM_PROG) prog[mem_addr[4:0]] = mem_wdata;
      if (mem_op === fsu_pkg::MEM_PROG) prog_cnt++;
      if (mem_op === fsu_pkg::MEM_ERASE) erase_cnt++;
    end
  end

  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    chk(s_axi_bvalid, 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    chk(s_axi_rvalid, 1'b1);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(d, e);
  endtask : rchk

  // waits until the masked control bits read back low
  task automatic poll(input logic [7:0] m);
    for (int i = 0; i < 100; i++) begin
      rd(8'h00);
      if ((d & m) == 8'h00) break;
    end
    chk(d & m, 8'h00);
  endtask : poll

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  initial begin
    #400000;
    err_total++;
    stop_test;
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {aresetn, unlock_ok, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0_0000;
    {s_axi_wdata, s_axi_wstrb} = 36'h0_0000_0001;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) if (i != 1) rchk(8'(i * 4), 8'h00);
    rd(8'h04);
    chk(r, fsu_pkg::RESP_SLVERR);
    wr(8'h1c, 8'h55);
    chk(r, fsu_pkg::RESP_SLVERR);
    $display("reset and map test done");
    wr(8'h0c, 8'h05);
    wr(8'h14, 8'h34);
    wr(8'h18, 8'h12);
    rchk(8'h0c, 8'h05);
    wr(8'h00, 8'h04);
    rchk(8'h00, 8'h00);
    wr(8'h00, 8'h80);
    rchk(8'h00, 8'h00);
    @(posedge aclk) unlock_ok <= 1'b1;
    @(posedge aclk) unlock_ok <= 1'b0;
    rchk(8'h00, 8'h80);
    $display("enable test done");
    wr(8'h08, 8'h01);
    rchk(8'h08, 8'h00);
    wr(8'h10, 8'h01);
    wr(8'h0c, 8'h3c);
    for (int i = 0; i < 5; i++) begin
      wr(8'h14, 8'(i));
      wr(8'h18, 8'(8'ha0 + i));
    end
    wr(8'h14, 8'h77);
    rchk(8'h0c, 8'h3f);
    rchk(8'h10, 8'h01);
    $display("buffer load test done");
    wr(8'h00, 8'h94);
    poll(8'h04);
    chk(erase_cnt, 1);
    chk(last_addr, 14'h0120);
    wr(8'h00, 8'h84);
    poll(8'h04);
    chk(prog_cnt, 32);
    for (int i = 0; i < 3; i++) chk(prog[28 + i], {8'(8'ha0 + i), 8'(i)});
    chk(prog[31], 16'ha404);
    chk(prog[0], fsu_pkg::BUF_CLEAR_VALUE);
    chk(last_addr, 14'h013f);
    wr(8'h00, 8'h84);
    poll(8'h04);
    chk(prog[31], fsu_pkg::BUF_CLEAR_VALUE);
    $display("erase and write test done");
    wr(8'h00, 8'hb3);
    poll(8'h01);
    rchk(8'h14, 8'h65);
    rchk(8'h18, 8'h5b);
    wr(8'h00, 8'ha4);
    poll(8'h04);
    chk(prog_cnt + erase_cnt, 65);
    wr(8'h08, 8'h01);
    wr(8'h18, 8'h66);
    wr(8'h00, 8'h84);
    poll(8'h04);
    chk(prog[31], 16'h6665);
    wr(8'h00, 8'h00);
    wr(8'h0c, 8'h00);
    wr(8'h18, 8'h11);
    rchk(8'h0c, 8'h00);
    $display("read and mode test done");
    stop_test;
  end
endmodule : tb
